// >>> hdl/io_interrupt_and_trap_request_logic.v
// Priority interrupt module and block-transfer controller request logic
`timescale 1ns/1ps
`include "io_req_consts.vh"
module io_interrupt_and_trap_request_logic #(
   parameter LEVELS = `LEVELS,
   parameter ADDR_W = `ADDR_W
) (
   input wire clk_sys,
   input wire rstn,
   // Bus-side inputs, active high here (pin inversion is outside)
   input wire request_sample_clock,
   input wire request_acknowledge_line,
   input wire [LEVELS-1:0] periph_irq,
   input wire peripheral_trap_request,
   input wire trap_dir_out,
   // Straps and setup, from same-domain logic
   input wire [LEVELS*3-1:0] prio_map,
   input wire [ADDR_W-1:0] pim_vec_base,
   input wire [1:0] sys_vec_sel,
   input wire sys_vec_req,
   input wire xfer_load,
   input wire [ADDR_W-1:0] xfer_start,
   input wire [ADDR_W-1:0] xfer_final,
   // Requests toward the processor
   output wire interrupt_request_line,
   output wire trap_in_request,
   output wire trap_out_request,
   output wire decode_inhibit,
   // Bus drive, output enable low while driving
   output reg [`BUS_W-1:0] bus_out,
   output reg bus_oe_n,
   output reg xfer_busy,
   output reg xfer_done
);
   localparam S_IDLE = 3'b001;
   localparam S_WAIT = 3'b010;
   localparam S_DRIVE = 3'b100;

   // ---------------------------------------------------------------
   // Input synchronisation
   // ---------------------------------------------------------------
   wire [LEVELS+3:0] raw_in;
   wire [LEVELS+3:0] sync_in;
   wire [LEVELS+3:0] fall_in;
   assign raw_in = {request_sample_clock, request_acknowledge_line,
                    peripheral_trap_request, trap_dir_out, periph_irq};
   req_sync #(.W(LEVELS+4)) u_sync (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .din(raw_in),
      .dout(sync_in),
      .fall(fall_in)
   );
   wire [LEVELS-1:0] irq_s = sync_in[LEVELS-1:0];
   wire dir_out_s = sync_in[LEVELS];
   wire trq_s = sync_in[LEVELS+1];
   wire ack_s = sync_in[LEVELS+2];
   wire ack_fall = fall_in[LEVELS+2];
   // Sample clock is gated off in acknowledge; guard anyway
   wire sample = fall_in[LEVELS+3] & ~ack_s;

   // ---------------------------------------------------------------
   // Priority interrupt module
   // ---------------------------------------------------------------
   reg [LEVELS-1:0] irq_q;
   reg sys_q;
   reg [2:0] int_st_q;
   reg [LEVELS-1:0] ranked;
   reg [2:0] win_lvl;
   reg win_any;
   integer k;
   integer j;
   integer m;
   // Declared early: the interrupt side must see who owns the bus
   reg [2:0] trp_st_q;
   wire xfer_owner = (trp_st_q == S_DRIVE);

   // Map each request onto its wired rank slot; rank 0 is highest
   always @* begin
      ranked = {LEVELS{1'b0}};
      for (k = 0; k < LEVELS; k = k + 1) begin
         if (irq_q[k]) begin
            ranked[prio_map[k*3 +: 3]] = 1'b1;
         end
      end
   end

   // Lowest set rank wins; result is the physical level behind it
   always @* begin
      win_lvl = 3'h0;
      win_any = 1'b0;
      for (j = LEVELS-1; j >= 0; j = j - 1) begin
         if (ranked[j]) begin
            win_any = 1'b1;
            win_lvl = j[2:0];
         end
      end
   end

   reg [2:0] phys_lvl;
   always @* begin
      phys_lvl = 3'h0;
      for (m = 0; m < LEVELS; m = m + 1) begin
         if (prio_map[m*3 +: 3] == win_lvl) begin
            phys_lvl = m[2:0];
         end
      end
   end

   reg [2:0] held_lvl_q;
   reg held_sys_q;
   // Vector per level: two words per level from the strapped base
   wire [ADDR_W-1:0] pim_vec = pim_vec_base + {{(ADDR_W-4){1'b0}}, held_lvl_q, 1'b0};
   reg [ADDR_W-1:0] sys_vec;
   always @* begin
      case (sys_vec_sel)
         `VEC_MP_HALT_SEL: sys_vec = `VEC_MP_HALT;
         `VEC_POWER_SEL: sys_vec = `VEC_POWER_FAIL;
         `VEC_RTC_SEL: sys_vec = `VEC_RTC;
         default: sys_vec = `VEC_MP_HALT;
      endcase
   end

   // Requests latch on sample edges; the served one clears at delivery
   always @(posedge clk_sys) begin
      if (!rstn) begin
         irq_q <= {LEVELS{1'b0}};
         sys_q <= 1'b0;
         int_st_q <= S_IDLE;
         held_lvl_q <= 3'h0;
         held_sys_q <= 1'b0;
      end else begin
         if (sample) begin
            irq_q <= irq_q | irq_s;
            sys_q <= sys_q | sys_vec_req;
         end
         case (int_st_q)
            S_IDLE: begin
               if (sys_q || win_any) begin
                  held_sys_q <= sys_q;
                  held_lvl_q <= phys_lvl;
                  int_st_q <= S_WAIT;
               end
            end
            S_WAIT: begin
               if (ack_s && !xfer_owner) begin
                  int_st_q <= S_DRIVE;
               end
            end
            S_DRIVE: begin
               // Release after the address phase ends
               if (ack_fall) begin
                  if (held_sys_q) begin
                     sys_q <= 1'b0;
                  end else begin
                     irq_q[held_lvl_q] <= 1'b0;
                  end
                  int_st_q <= S_IDLE;
               end
            end
            default: int_st_q <= S_IDLE;
         endcase
      end
   end

   assign interrupt_request_line = (int_st_q == S_WAIT);

   // ---------------------------------------------------------------
   // Block-transfer controller
   // ---------------------------------------------------------------
   reg [ADDR_W-1:0] cur_q;
   reg [ADDR_W-1:0] fin_q;
   reg dir_q;
   reg trq_q;

   // Trap has bus priority over the module when both are waiting at the same acknowledge
   always @(posedge clk_sys) begin
      if (!rstn) begin
         cur_q <= {ADDR_W{1'b0}};
         fin_q <= {ADDR_W{1'b0}};
         trp_st_q <= S_IDLE;
         dir_q <= 1'b0;
         trq_q <= 1'b0;
         xfer_busy <= 1'b0;
         xfer_done <= 1'b0;
      end else if (xfer_load) begin
         cur_q <= xfer_start;
         fin_q <= xfer_final;
         trp_st_q <= S_IDLE;
         trq_q <= 1'b0;
         xfer_busy <= 1'b1;
         xfer_done <= 1'b0;
      end else begin
         if (sample && trq_s && xfer_busy) begin
            trq_q <= 1'b1;
            dir_q <= dir_out_s;
         end
         case (trp_st_q)
            S_IDLE: begin
               if (trq_q) begin
                  trp_st_q <= S_WAIT;
               end
            end
            S_WAIT: begin
               if (ack_s && int_st_q != S_DRIVE) begin
                  trp_st_q <= S_DRIVE;
               end
            end
            S_DRIVE: begin
               if (ack_fall) begin
                  trq_q <= 1'b0;
                  trp_st_q <= S_IDLE;
                  if (cur_q == fin_q) begin
                     xfer_busy <= 1'b0;
                     xfer_done <= 1'b1;
                  end else begin
                     cur_q <= cur_q + {{(ADDR_W-1){1'b0}}, 1'b1};
                  end
               end
            end
            default: trp_st_q <= S_IDLE;
         endcase
      end
   end

   assign trap_in_request = (trp_st_q == S_WAIT) & ~dir_q;
   assign trap_out_request = (trp_st_q == S_WAIT) & dir_q;
   assign decode_inhibit = ack_s;

   // ---------------------------------------------------------------
   // Bus drive, registered; address phase only while acknowledged
   // ---------------------------------------------------------------
   always @(posedge clk_sys) begin
      if (!rstn) begin
         bus_out <= {`BUS_W{1'b0}};
         bus_oe_n <= 1'b1;
      end else if (xfer_owner && ack_s) begin
         bus_out <= {1'b0, cur_q};
         bus_oe_n <= 1'b0;
      end else if (int_st_q == S_DRIVE && ack_s) begin
         bus_out <= {1'b0, held_sys_q ? sys_vec : pim_vec};
         bus_oe_n <= 1'b0;
      end else begin
         // Released so other controllers on the shared bus can drive
         bus_out <= {`BUS_W{1'b0}};
         bus_oe_n <= 1'b1;
      end
   end
endmodule

// >>> hdl/io_req_consts.vh
// Constants for the I/O interrupt and trap request logic
`ifndef IO_REQ_CONSTS_VH
`define IO_REQ_CONSTS_VH
`define BUS_W 16
`define ADDR_W 15
`define LEVELS 8
`define VEC_MP_HALT 15'h0010
`define VEC_POWER_FAIL 15'h0020
`define VEC_RTC 15'h0024
`define VEC_PIM_LOW 15'h0040
`define VEC_PIM_HIGH 15'h0050
`define VEC_MP_HALT_SEL 2'h1
`define VEC_POWER_SEL 2'h2
`define VEC_RTC_SEL 2'h3
`define SAMPLE_NS_SLOW 990
`define SAMPLE_NS_FAST 660
`define CLK_NS 8
`endif

// >>> hdl/req_sync.v
// Two-stage synchroniser with falling-edge detect for bus-side inputs
`timescale 1ns/1ps
module req_sync #(
   parameter W = 4
) (
   input wire clk_sys,
   input wire rstn,
   input wire [W-1:0] din,
   output wire [W-1:0] dout,
   output wire [W-1:0] fall
);
   reg [W-1:0] s1_q;
   reg [W-1:0] s2_q;
   reg [W-1:0] s3_q;

   // First stage feeds only the second stage; the third is history for edges
   always @(posedge clk_sys) begin
      if (!rstn) begin
         s1_q <= {W{1'b0}};
         s2_q <= {W{1'b0}};
         s3_q <= {W{1'b0}};
      end else begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   assign dout = s2_q;
   assign fall = s3_q & ~s2_q;
endmodule

// >>> test/io_req_assertions.sv
// Assertion checker for the request logic
`timescale 1ns/1ps
`include "io_req_consts.vh"
module io_req_chk #(
   parameter LEVELS = 8,
   parameter ADDR_W = 15
) (
   input wire clk_sys,
   input wire rstn,
   input wire request_acknowledge_line,
   input wire [LEVELS-1:0] periph_irq,
   input wire xfer_load,
   input wire interrupt_request_line,
   input wire trap_in_request,
   input wire trap_out_request,
   input wire decode_inhibit,
   input wire [`BUS_W-1:0] bus_out,
   input wire bus_oe_n,
   input wire xfer_busy,
   input wire xfer_done
);
   // ----------
   // Properties
   // ----------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   // Last trap address driven; a reload restarts the step check
   reg [ADDR_W-1:0] last_q;
   reg seen_q;
   // Requests drop once driving starts, so remember which kind asked last
   reg kind_q;
   always @(posedge clk_sys) begin
      if (!rstn) kind_q <= 1'b0;
      else if ((trap_in_request || trap_out_request) && !interrupt_request_line) kind_q <= 1'b1;
      else if (interrupt_request_line && !(trap_in_request || trap_out_request)) kind_q <= 1'b0;
   end
   wire trap_drv = !bus_oe_n && kind_q;
   always @(posedge clk_sys) begin
      if (!rstn || xfer_load) seen_q <= 1'b0;
      else if (trap_drv) seen_q <= 1'b1;
      if (trap_drv) last_q <= bus_out[ADDR_W-1:0];
   end
   AST_IRQ_RISE: assert property ($rose(|periph_irq) && !request_acknowledge_line
      |-> ##[1:30] (interrupt_request_line || request_acknowledge_line)) else $error("no irq");
   AST_OE_ON_ACK: assert property ($fell(bus_oe_n) |-> decode_inhibit)
      else $error("drive without ack");
   AST_DRIVE_TIME: assert property ($rose(decode_inhibit) && (interrupt_request_line ||
      trap_in_request || trap_out_request) |-> ##[1:3] !bus_oe_n) else $error("late drive");
   AST_INHIBIT_ON: assert property ($rose(request_acknowledge_line)
      |-> ##[1:4] decode_inhibit) else $error("no inhibit");
   AST_INHIBIT_OFF: assert property ($fell(request_acknowledge_line)
      |-> ##[1:4] !decode_inhibit) else $error("inhibit stuck");
   AST_ONE_DIR: assert property (!(trap_in_request && trap_out_request))
      else $error("both trap lines");
   AST_REQ_HOLD: assert property (trap_in_request && !decode_inhibit && !$past(decode_inhibit)
      && !$past(decode_inhibit, 2) |=> trap_in_request) else $error("request dropped");
   AST_ADDR_STEP: assert property ($fell(bus_oe_n) && trap_drv && seen_q
      |-> bus_out[ADDR_W-1:0] == last_q + 1'b1) else $error("no address step");
   AST_DONE_IDLE: assert property ($rose(xfer_done) |-> !xfer_busy)
      else $error("done while busy");
endmodule
bind io_interrupt_and_trap_request_logic io_req_chk #(.LEVELS(LEVELS), .ADDR_W(ADDR_W)) chk (
   .clk_sys(clk_sys), .rstn(rstn), .request_acknowledge_line(request_acknowledge_line),
   .periph_irq(periph_irq), .xfer_load(xfer_load), .decode_inhibit(decode_inhibit),
   .interrupt_request_line(interrupt_request_line), .trap_in_request(trap_in_request),
   .trap_out_request(trap_out_request), .bus_out(bus_out), .bus_oe_n(bus_oe_n),
   .xfer_busy(xfer_busy), .xfer_done(xfer_done));

// >>> test/proc_bus_model.sv
// Processor side model: sample clock and acknowledge
`timescale 1ns/1ps
module proc_bus_model #(
   parameter DLY = 2
) (
   input wire clk_sys,
   input wire irq_req,
   input wire tin_req,
   input wire tout_req,
   input wire bus_oe_n,
   input wire [15:0] bus_out,
   output reg sample_clk,
   output reg ack,
   output reg [15:0] got_addr,
   output reg [1:0] got_kind,
   output integer got_n
);
   // Free-running sample clock, frozen while acknowledging
   initial begin
      sample_clk = 1'b1;
      #3;
      forever #32 if (!ack) sample_clk = ~sample_clk;
   end
   // Acknowledge a request, take the address word, then release
   initial begin
      integer i;
      ack = 1'b0;
      got_n = 0;
      forever begin
         @(posedge clk_sys);
         if (irq_req | tin_req | tout_req) begin
            repeat (DLY) @(posedge clk_sys);
            // Kind is taken while the requests still stand; they drop once driving
            #1 got_kind = {tout_req, tin_req};
            ack = 1'b1;
            for (i = 0; i < 20 && bus_oe_n !== 1'b0; i++) @(posedge clk_sys) #1;
            got_addr = bus_out;
            got_n++;
            ack = 1'b0;
            // Free cycles between steals stand for program execution
            repeat (6) @(posedge clk_sys);
         end
      end
   end
endmodule

// >>> test/tb_top.sv
// Testbench for the interrupt and trap request logic
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
   $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
   reg clk_sys, rstn, trq, dir, sreq, load;
   reg [7:0] irq;
   reg [23:0] pmap;
   reg [1:0] ssel;
   reg [14:0] xs, xf;
   wire irl, tin, tout, ack, sclk, busy, done;
   wire [15:0] bus, gaddr;
   wire [1:0] gkind;
   wire [31:0] got_n;
   wire oe_n;
   integer err_count = 0;
   integer checks_done = 0;
   io_interrupt_and_trap_request_logic DUT (.clk_sys(clk_sys), .rstn(rstn),
      .request_sample_clock(sclk), .request_acknowledge_line(ack), .periph_irq(irq),
      .peripheral_trap_request(trq), .trap_dir_out(dir), .prio_map(pmap),
      .pim_vec_base(15'h0040), .sys_vec_sel(ssel), .sys_vec_req(sreq), .xfer_load(load),
      .xfer_start(xs), .xfer_final(xf), .interrupt_request_line(irl), .trap_in_request(tin),
      .trap_out_request(tout), .decode_inhibit(), .bus_out(bus), .bus_oe_n(oe_n),
      .xfer_busy(busy), .xfer_done(done));
   proc_bus_model proc (.clk_sys(clk_sys), .irq_req(irl), .tin_req(tin), .tout_req(tout),
      .bus_oe_n(oe_n), .bus_out(bus), .sample_clk(sclk), .ack(ack), .got_addr(gaddr),
      .got_kind(gkind), .got_n(got_n));
   // -----------
   // Bench tasks
   // -----------
   task step; begin @(posedge clk_sys); #1; end endtask
   task stop_test;
      begin
         if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
         else $display("TESTS FAILED");
         $finish;
      end
   endtask
   task wait_word(input [14:0] exp);
      integer n0, i;
      begin
         n0 = got_n;
         for (i = 0; i < 300 && got_n == n0; i++) step;
         `CHK(gaddr[14:0], exp)
      end
   endtask
   // Two levels at once; the higher rank is served first
   task irq_pair(input [23:0] map, input [2:0] hi, input [2:0] lo);
      begin
         pmap = map;
         irq = (8'h01 << hi) | (8'h01 << lo);
         wait (ack === 1'b1);
         irq[hi] = 1'b0;
         wait_word(15'h0040 + 2 * hi);
         wait_word(15'h0040 + 2 * lo);
         irq = 8'h00;
         repeat (16) step;
      end
   endtask
   task sys_one(input [1:0] sel, input [14:0] exp);
      begin
         ssel = sel;
         sreq = 1'b1;
         wait_word(exp);
         sreq = 1'b0;
         repeat (16) step;
      end
   endtask
   // Block transfer; a request after the last word is refused
   task xfer(input d, input [14:0] a0, input [14:0] a1);
      reg [14:0] a;
      begin
         dir = d;
         xs = a0;
         xf = a1;
         load = 1'b1;
         step;
         load = 1'b0;
         for (a = a0; a != a1 + 1'b1; a = a + 1'b1) begin
            trq = 1'b1;
            wait (ack === 1'b1);
            trq = 1'b0;
            wait_word(a);
            `CHK(gkind, d ? 2'b10 : 2'b01)
            repeat (16) step;
         end
         `CHK({done, busy}, 2'b10)
         trq = 1'b1;
         repeat (40) step;
         `CHK(tin | tout, 1'b0)
         trq = 1'b0;
      end
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      err_count++;
      stop_test;
   end
   initial begin
      {rstn, trq, dir, sreq, load, irq, ssel, xs, xf} = 0;
      pmap = 24'hfac688;
      repeat (8) step;
      rstn = 1'b1;
      step;
      irq_pair(24'hfac688, 3'd2, 3'd5);
      irq_pair(24'h053977, 3'd6, 3'd1);
      sys_one(2'h1, 15'h0010);
      sys_one(2'h2, 15'h0020);
      sys_one(2'h3, 15'h0024);
      xfer(1'b0, 15'h0100, 15'h0102);
      xfer(1'b1, 15'h7ffe, 15'h7fff);
      stop_test;
   end
endmodule
